//--- hdl/nfcps_consts.vh
// constants for the nfc peer framing and field sequencer
`ifndef NFCPS_CONSTS_VH
`define NFCPS_CONSTS_VH
// register offsets
`define NFCPS_REG_MODE    4'h0
`define NFCPS_REG_TXCNT   4'h1
`define NFCPS_REG_CMD     4'h2
`define NFCPS_REG_EVENTS  4'h3
`define NFCPS_REG_STATUS  4'h4
`define NFCPS_REG_GPTIME  4'h5
`define NFCPS_REG_NRTIME  4'h6
`define NFCPS_REG_MRTIME  4'h7
`define NFCPS_REG_TXDATA  4'h8
`define NFCPS_REG_RXDATA  4'h9
// mode register fields
`define NFCPS_MODE_ACTIVE  0
`define NFCPS_MODE_SYNCFR  1
`define NFCPS_MODE_ISOA    2
`define NFCPS_MODE_TF106   3
`define NFCPS_MODE_AUTORSP 4
`define NFCPS_MODE_TXON    5
`define NFCPS_MODE_FDON    6
`define NFCPS_MODE_AMON    7
`define NFCPS_MODE_PMON    8
`define NFCPS_MODE_RESET   9'h000
// commands
`define NFCPS_CMD_INIT_ON  8'h01
`define NFCPS_CMD_RESP_ON  8'h02
`define NFCPS_CMD_TX_CRC   8'h03
`define NFCPS_CMD_PRESET   8'h04
// event bits
`define NFCPS_EV_CAT   0
`define NFCPS_EV_CAC   1
`define NFCPS_EV_NRE   2
`define NFCPS_EV_EON   3
`define NFCPS_EV_EOF   4
`define NFCPS_EV_SFE   5
`define NFCPS_EV_CRCE  6
`define NFCPS_EV_RXE   7
`define NFCPS_EV_W     8
// frame bytes
`define NFCPS_START_BYTE 8'hf0
`define NFCPS_SYNC1      8'hb2
`define NFCPS_SYNC2      8'h4d
`define NFCPS_CRC_INIT   16'h6363
// guard times in ns and cycles at 10 ns
`define NFCPS_CLK_NS     10
`define NFCPS_IRFG_NS    5000000
`define NFCPS_ARFG_NS    75000
`define NFCPS_CA_NS      75000
`endif

//--- hdl/nfcps_crc.v
// crc-16 update over one byte, lsb first
`default_nettype none
module nfcps_crc (
  input  wire [15:0] crc_i,   // running crc
  input  wire [7:0]  data_i,  // byte
  output reg  [15:0] crc_o    // updated crc
);
  integer k;
  reg [15:0] c;
  // reflected polynomial 0x8408
  always @* begin
    c = crc_i ^ {8'h00, data_i};
    for (k = 0; k < 8; k = k + 1) begin
      if (c[0]) begin
        c = (c >> 1) ^ 16'h8408;
      end else begin
        c = c >> 1;
      end
    end
    crc_o = c;
  end
endmodule
`default_nettype wire

//--- hdl/nfcps_timer.v
// down counter that pulses when it reaches zero
`default_nettype none
module nfcps_timer (
  input  wire        clk_i,    // clock
  input  wire        reset_i,  // sync reset
  input  wire        start_i,  // load and run
  input  wire        stop_i,   // abort
  input  wire [23:0] load_i,   // cycles
  output reg         run_o,    // counting
  output reg         done_o    // expiry pulse
);
  reg [23:0] count; // remaining cycles
  // start wins over stop so a restart is never lost
  always @(posedge clk_i) begin
    if (reset_i) begin
      count  <= 24'h000000;
      run_o  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count <= (load_i == 24'h000000) ? 24'h000001 : load_i;
        run_o <= 1'b1;
      end else if (stop_i) begin
        run_o <= 1'b0;
      end else if (run_o) begin
        if (count == 24'h000001) begin
          run_o  <= 1'b0;
          done_o <= 1'b1;
        end
        count <= count - 24'h000001;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/nfcps_sequencer.v
// framing and rf field sequencer for a peer initiator
// Operation
// - sync mode: hunt preamble after transmit
// - after sync, store length, payload; check crc
// - initial field-on: avoid collision, tx on, done
// - external field: collision event; host retries
// - transport frame when enabled in 106 mode
// - send start, length, data, two crc bytes
// - length equals byte count plus one
// - receive: check start, store length, data
// - bad start: store anyway, soft framing error
// - active: field via commands or auto response
// - peer mode enables detector; pick threshold
// - active: field off after message, gp delay
// - preset enables am, disables pm in active mode
// - preset in active mode sets transport enable
// - after field off: no-response timer, event
// - target field on: event, mask, then receive
// - target field off: event, auto response on
`default_nettype none
`include "nfcps_consts.vh"
module nfcps_sequencer #(
  parameter IRFG_CYC = `NFCPS_IRFG_NS / `NFCPS_CLK_NS  // initial guard, cycles
) (
  input  wire        clk_i,        // clock
  input  wire        reset_i,      // sync reset
  input  wire [3:0]  addr_i,       // register index
  input  wire [15:0] wdata_i,      // write data
  input  wire        wr_i,         // write strobe
  input  wire        rd_i,         // read strobe
  output reg  [15:0] rdata_o,      // read data
  input  wire        ext_field_i,  // field detector pin
  input  wire        rx_valid_i,   // demod byte strobe (same domain)
  input  wire [7:0]  rx_byte_i,    // demod byte
  input  wire        rx_end_i,     // end of received frame
  input  wire        tx_ready_i,   // modulator takes a byte
  output reg         tx_valid_o,   // byte to modulator
  output reg  [7:0]  tx_byte_o,    // byte value
  output reg         tx_last_o,    // final byte of frame
  output reg         field_on_o,   // transmitter enable
  output reg         thresh_ca_o,  // collision threshold in use
  output reg         rx_window_o   // receiver observed
);
  localparam [23:0] ARFG_CYC = `NFCPS_ARFG_NS / `NFCPS_CLK_NS; // response guard
  localparam [23:0] CA_CYC   = `NFCPS_CA_NS / `NFCPS_CLK_NS;   // collision window
  // field states
  localparam [2:0] F_IDLE = 3'h0, F_CA = 3'h1, F_GUARD = 3'h2, F_ON = 3'h3;
  localparam [2:0] F_HOLD = 3'h4, F_NRT = 3'h5, F_PEER = 3'h6;
  // transmit states
  localparam [2:0] T_IDLE = 3'h0, T_HEAD = 3'h1, T_SIZE = 3'h2, T_DATA = 3'h3;
  localparam [2:0] T_CRC1 = 3'h4, T_CRC2 = 3'h5;
  // receive states
  localparam [1:0] R_OFF = 2'h0, R_HUNT = 2'h1, R_SYNC = 2'h2, R_BODY = 2'h3;

  reg [1:0]  fd_sync;             // detector pin synchroniser
  reg        fd_prev;             // last synced level
  reg [8:0]  mode;                // mode register
  reg [7:0]  txcnt;               // transmitted byte count
  reg [8:0]  events;              // sticky event bits
  reg [15:0] gp_time, nr_time, mr_time; // timer loads
  reg [2:0]  fstate;              // field state
  reg [2:0]  tstate;              // transmit state
  reg [1:0]  rstate;              // receive state
  reg [7:0]  tx_idx;              // bytes of data sent
  reg [15:0] tx_crc, rx_crc;      // running crc
  reg [7:0]  fifo_tx [0:15];      // transmit store
  reg [7:0]  fifo_rx [0:15];      // receive store
  reg [3:0]  rx_wp, rx_rp;        // receive pointers
  reg [4:0]  rx_lvl;              // receive fill
  reg        resp_ca;             // response guard due after avoidance
  reg        tx_done;             // frame just finished
  wire       fd = fd_sync[1];     // synced detector
  wire       fd_rise = fd & ~fd_prev;
  wire       fd_fall = ~fd & fd_prev;
  wire       tf_mode = mode[`NFCPS_MODE_TF106] & mode[`NFCPS_MODE_ISOA];
  wire       cmd_wr = wr_i & (addr_i == `NFCPS_REG_CMD);
  wire [7:0] cmd = wdata_i[7:0];
  wire [15:0] next_tx_crc, next_rx_crc;
  reg  [7:0] crc_in_tx;           // byte fed to tx crc
  reg  [8:0] ev_set;              // events this cycle
  reg        tstart, tstop;       // main timer control
  reg [23:0] tload;               // main timer load
  wire       t_done, t_run;
  integer    i;

  nfcps_crc u_txcrc (.crc_i(tx_crc), .data_i(crc_in_tx), .crc_o(next_tx_crc));
  nfcps_crc u_rxcrc (.crc_i(rx_crc), .data_i(rx_byte_i), .crc_o(next_rx_crc));
  nfcps_timer u_tmr (.clk_i(clk_i), .reset_i(reset_i), .start_i(tstart),
    .stop_i(tstop), .load_i(tload), .run_o(t_run), .done_o(t_done));

  // pin passes two flops before use
  always @(posedge clk_i) begin
    if (reset_i) begin
      fd_sync <= 2'b00;
      fd_prev <= 1'b0;
    end else begin
      fd_sync <= {fd_sync[0], ext_field_i};
      fd_prev <= fd_sync[1];
    end
  end

  // byte the tx crc sees: start, length or data
  always @* begin
    if (tstate == T_HEAD) begin
      crc_in_tx = `NFCPS_START_BYTE;
    end else if (tstate == T_SIZE) begin
      crc_in_tx = txcnt + 8'h01;
    end else begin
      crc_in_tx = fifo_tx[tx_idx[3:0]];
    end
  end

  // field sequencer decisions and timer control
  always @* begin
    ev_set = 9'h000;
    tstart = 1'b0;
    tstop  = 1'b0;
    tload  = 24'h000000;
    case (fstate)
      F_CA: begin
        if (fd) begin
          ev_set[`NFCPS_EV_CAC] = 1'b1;
          tstop = 1'b1;
        end else if (t_done) begin
          tstart = 1'b1;
          tload  = resp_ca ? ARFG_CYC : IRFG_CYC[23:0];
        end
      end
      F_GUARD: begin
        if (t_done) begin
          ev_set[`NFCPS_EV_CAT] = 1'b1;
        end
      end
      F_ON: begin
        if (tx_done & mode[`NFCPS_MODE_ACTIVE]) begin
          tstart = 1'b1;
          tload  = {8'h00, gp_time};
        end
      end
      F_HOLD: begin
        if (t_done) begin
          tstart = 1'b1;
          tload  = {8'h00, nr_time};
        end
      end
      F_NRT: begin
        if (fd_rise) begin
          ev_set[`NFCPS_EV_EON] = 1'b1;
          tstart = 1'b1;
          tload  = {8'h00, mr_time};
        end else if (t_done) begin
          ev_set[`NFCPS_EV_NRE] = 1'b1;
        end
      end
      F_PEER: begin
        if (fd_fall) begin
          ev_set[`NFCPS_EV_EOF] = 1'b1;
          if (mode[`NFCPS_MODE_AUTORSP]) begin
            tstart = 1'b1;
            tload  = CA_CYC;
          end
        end
      end
      default: begin
        tstart = 1'b0;
      end
    endcase
    if (cmd_wr & (cmd == `NFCPS_CMD_INIT_ON || cmd == `NFCPS_CMD_RESP_ON)) begin
      tstart = 1'b1;
      tload  = CA_CYC;
    end
    if (rx_end_i & (rstate == R_BODY) & (rx_crc != 16'h0000)) begin
      ev_set[`NFCPS_EV_CRCE] = 1'b1;
    end
    if (rx_end_i & (rstate != R_OFF)) begin
      ev_set[`NFCPS_EV_RXE] = 1'b1;
    end
    if (rx_valid_i & (rstate == R_HUNT) & tf_mode & (rx_byte_i != 8'h00) &
        (rx_byte_i != `NFCPS_START_BYTE)) begin
      ev_set[`NFCPS_EV_SFE] = 1'b1;
    end
  end

  // field state machine and mode bits
  always @(posedge clk_i) begin
    if (reset_i) begin
      fstate  <= F_IDLE;
      mode    <= `NFCPS_MODE_RESET;
      resp_ca <= 1'b0;
    end else begin
      if (wr_i & (addr_i == `NFCPS_REG_MODE)) begin
        mode <= wdata_i[8:0];
        if (wdata_i[`NFCPS_MODE_ACTIVE]) begin
          mode[`NFCPS_MODE_FDON] <= 1'b1;
        end
      end
      if (cmd_wr & (cmd == `NFCPS_CMD_PRESET)) begin
        mode[`NFCPS_MODE_AMON] <= 1'b1;
        mode[`NFCPS_MODE_PMON] <= ~mode[`NFCPS_MODE_ACTIVE];
        if (mode[`NFCPS_MODE_ACTIVE]) begin
          mode[`NFCPS_MODE_TF106] <= 1'b1;
        end
      end
      if ((fstate == F_CA) & ~fd & t_done) begin
        mode[`NFCPS_MODE_TXON] <= 1'b1;
      end
      if ((fstate == F_HOLD) & t_done) begin
        mode[`NFCPS_MODE_TXON] <= 1'b0;
      end
      // automatic entry takes the response guard; a command below overrides
      if ((fstate == F_PEER) & fd_fall) begin
        resp_ca <= 1'b1;
      end
      if (cmd_wr & (cmd == `NFCPS_CMD_INIT_ON || cmd == `NFCPS_CMD_RESP_ON)) begin
        fstate  <= F_CA;
        resp_ca <= (cmd == `NFCPS_CMD_RESP_ON);
      end else begin
        case (fstate)
          F_CA:    fstate <= fd ? F_IDLE : (t_done ? F_GUARD : F_CA);
          F_GUARD: fstate <= t_done ? F_ON : F_GUARD;
          F_ON:    fstate <= (tx_done & mode[`NFCPS_MODE_ACTIVE]) ? F_HOLD : F_ON;
          F_HOLD:  fstate <= t_done ? F_NRT : F_HOLD;
          F_NRT:   fstate <= fd_rise ? F_PEER : (t_done ? F_IDLE : F_NRT);
          F_PEER:  fstate <= (fd_fall & mode[`NFCPS_MODE_AUTORSP]) ? F_CA :
                             (fd_fall ? F_IDLE : F_PEER);
          default: fstate <= F_IDLE;
        endcase
      end
    end
  end

  // transmit framer
  always @(posedge clk_i) begin
    if (reset_i) begin
      tstate     <= T_IDLE;
      tx_idx     <= 8'h00;
      tx_crc     <= `NFCPS_CRC_INIT;
      tx_valid_o <= 1'b0;
      tx_byte_o  <= 8'h00;
      tx_last_o  <= 1'b0;
      tx_done    <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tstate == T_IDLE) begin
        if (cmd_wr & (cmd == `NFCPS_CMD_TX_CRC) & tf_mode) begin
          tstate     <= T_HEAD;
          tx_valid_o <= 1'b1;
          tx_byte_o  <= `NFCPS_START_BYTE;
          tx_crc     <= `NFCPS_CRC_INIT;
          tx_idx     <= 8'h00;
        end
      end else if (tx_ready_i & tx_valid_o) begin
        case (tstate)
          T_HEAD: begin
            tx_crc    <= next_tx_crc;
            tstate    <= T_SIZE;
            tx_byte_o <= txcnt + 8'h01;
          end
          T_SIZE: begin
            tx_crc    <= next_tx_crc;
            tstate    <= (txcnt == 8'h00) ? T_CRC1 : T_DATA;
            tx_byte_o <= (txcnt == 8'h00) ? next_tx_crc[7:0] : fifo_tx[0];
            tx_last_o <= 1'b0;
          end
          T_DATA: begin
            tx_crc <= next_tx_crc;
            tx_idx <= tx_idx + 8'h01;
            if (tx_idx + 8'h01 == txcnt) begin
              tstate    <= T_CRC1;
              tx_byte_o <= next_tx_crc[7:0];
            end else begin
              tx_byte_o <= fifo_tx[tx_idx[3:0] + 4'h1];
            end
          end
          T_CRC1: begin
            tstate    <= T_CRC2;
            tx_byte_o <= tx_crc[15:8];
            tx_last_o <= 1'b1;
          end
          default: begin
            tstate     <= T_IDLE;
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            tx_done    <= 1'b1;
          end
        endcase
      end
    end
  end

  // receive deframer: hunt, sync or start byte, body into store
  always @(posedge clk_i) begin
    if (reset_i) begin
      rstate   <= R_OFF;
      rx_crc   <= `NFCPS_CRC_INIT;
      rx_wp    <= 4'h0;
    end else begin
      // each hunt starts from a fresh crc so a cut frame cannot leak into the next
      if (tx_done & ~mode[`NFCPS_MODE_ACTIVE]) begin
        rstate <= R_HUNT;
        rx_crc <= `NFCPS_CRC_INIT;
      end else if ((fstate == F_PEER) & t_done) begin
        rstate <= R_HUNT;
        rx_crc <= `NFCPS_CRC_INIT;
      end else if (rx_end_i) begin
        rstate <= R_OFF;
      end else if (rx_valid_i) begin
        case (rstate)
          R_HUNT: begin
            if (mode[`NFCPS_MODE_SYNCFR] & (rx_byte_i == `NFCPS_SYNC1)) begin
              rstate <= R_SYNC;
            end else if (~mode[`NFCPS_MODE_SYNCFR] & (rx_byte_i != 8'h00)) begin
              // start byte is covered by the crc but stored only outside transport mode
              rstate <= R_BODY;
              rx_crc <= next_rx_crc;
              if (~tf_mode) begin
                fifo_rx[rx_wp] <= rx_byte_i;
                rx_wp          <= rx_wp + 4'h1;
              end
            end
          end
          R_SYNC: begin
            rstate <= (rx_byte_i == `NFCPS_SYNC2) ? R_BODY : R_HUNT;
          end
          R_BODY: begin
            rx_crc         <= next_rx_crc;
            fifo_rx[rx_wp] <= rx_byte_i;
            rx_wp          <= rx_wp + 4'h1;
          end
          default: rstate <= R_OFF;
        endcase
      end
    end
  end

  // host registers, events, reads; set wins over clear
  always @(posedge clk_i) begin
    if (reset_i) begin
      txcnt   <= 8'h00;
      events  <= 9'h000;
      gp_time <= 16'h0000;
      nr_time <= 16'h0000;
      mr_time <= 16'h0000;
      rdata_o <= 16'h0000;
      rx_rp   <= 4'h0;
      field_on_o  <= 1'b0;
      thresh_ca_o <= 1'b0;
      rx_window_o <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        fifo_tx[i] <= 8'h00;
      end
    end else begin
      events <= ev_set | ((rd_i & (addr_i == `NFCPS_REG_EVENTS)) ? 9'h000 : events);
      if (wr_i) begin
        case (addr_i)
          `NFCPS_REG_TXCNT:  txcnt   <= wdata_i[7:0];
          `NFCPS_REG_GPTIME: gp_time <= wdata_i;
          `NFCPS_REG_NRTIME: nr_time <= wdata_i;
          `NFCPS_REG_MRTIME: mr_time <= wdata_i;
          `NFCPS_REG_TXDATA: fifo_tx[wdata_i[11:8]] <= wdata_i[7:0];
          default: txcnt <= txcnt;
        endcase
      end
      rdata_o <= 16'h0000;
      if (rd_i) begin
        case (addr_i)
          `NFCPS_REG_MODE:   rdata_o <= {7'h00, mode};
          `NFCPS_REG_TXCNT:  rdata_o <= {8'h00, txcnt};
          `NFCPS_REG_EVENTS: rdata_o <= {7'h00, events};
          `NFCPS_REG_STATUS: rdata_o <= {3'h0, rx_lvl, rstate, tstate, fstate};
          `NFCPS_REG_GPTIME: rdata_o <= gp_time;
          `NFCPS_REG_NRTIME: rdata_o <= nr_time;
          `NFCPS_REG_MRTIME: rdata_o <= mr_time;
          `NFCPS_REG_RXDATA: begin
            rdata_o <= {8'h00, fifo_rx[rx_rp]};
            rx_rp   <= rx_rp + 4'h1;
          end
          default: rdata_o <= 16'h0000;
        endcase
      end
      field_on_o  <= mode[`NFCPS_MODE_TXON];
      thresh_ca_o <= (fstate == F_CA);
      rx_window_o <= (rstate != R_OFF) & mode[`NFCPS_MODE_AMON];
    end
  end

  // receive fill level shown to software
  always @* begin
    rx_lvl = {1'b0, rx_wp - rx_rp};
  end
endmodule
`default_nettype wire

//--- verification/nfcps_seq_monitor.sv
// assertion checker for the peer framing sequencer ports
`default_nettype none
`include "nfcps_consts.vh"
module nfcps_seq_monitor #(
  parameter IRFG_CYC = 50  // initial guard, cycles
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        ext_field_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_byte_i,
  input wire logic        rx_end_i,
  input wire logic        tx_ready_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_last_o,
  input wire logic        field_on_o,
  input wire logic        thresh_ca_o,
  input wire logic        rx_window_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] taken_cnt;  // bytes taken in the current frame
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // count taken bytes; the closing byte restarts the count
  always @(posedge clk_i) begin
    if (reset_i) begin
      taken_cnt <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      taken_cnt <= tx_last_o ? 8'h00 : taken_cnt + 8'h01;
    end
  end
  // byte handed over to the modulator
  sequence s_taken;
    tx_valid_o && tx_ready_i;
  endsequence
  // closing byte handed over
  sequence s_last_taken;
    s_taken ##0 tx_last_o;
  endsequence
  // host asks for the initial field-on
  sequence s_init_cmd;
    wr_i && addr_i == `NFCPS_REG_CMD && wdata_i[7:0] == `NFCPS_CMD_INIT_ON;
  endsequence
  AST_RESET_QUIET: assert property ($past(reset_i) |->
    !tx_valid_o && !field_on_o && !rx_window_o && !thresh_ca_o && rdata_o == 16'h0000)
    else $error("outputs not quiet after reset");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
    else $error("tx byte changed before it was taken");
  AST_TX_START_BYTE: assert property ($rose(tx_valid_o) |->
    tx_byte_o == `NFCPS_START_BYTE && !tx_last_o)
    else $error("frame does not open with the start byte");
  AST_LAST_WITH_VALID: assert property (tx_last_o |-> tx_valid_o)
    else $error("last flag without valid");
  AST_LAST_DROP: assert property (s_last_taken |=> !tx_valid_o)
    else $error("valid held after closing byte");
  AST_FRAME_MIN_SIZE: assert property (s_last_taken |-> taken_cnt >= 8'h03)
    else $error("frame shorter than start, length and crc");
  AST_START_FIRST: assert property (s_taken ##0 taken_cnt == 8'h00 |->
    tx_byte_o == `NFCPS_START_BYTE)
    else $error("first byte of frame is not the start byte");
  AST_CA_THRESH: assert property (s_init_cmd |-> ##[1:3] thresh_ca_o)
    else $error("collision threshold not used by field-on");
endmodule
bind nfcps_sequencer nfcps_seq_monitor #(.IRFG_CYC(IRFG_CYC)) u_mon (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_field_i(ext_field_i),
  .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_end_i(rx_end_i),
  .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
  .tx_last_o(tx_last_o), .field_on_o(field_on_o), .thresh_ca_o(thresh_ca_o),
  .rx_window_o(rx_window_o));
`default_nettype wire

//--- verification/nfcps_rf_peer.sv
// behavioural rf target: modulator sink, demod source, target field
`default_nettype none
module nfcps_rf_peer (
  input  wire logic       clk_i,        // clock
  input  wire logic       stall_i,      // take a byte only every other cycle
  input  wire logic       tx_valid_i,   // byte offered
  input  wire logic [7:0] tx_byte_i,    // byte value
  output logic            tx_ready_o,   // byte taken
  output logic            rx_valid_o,   // demod byte strobe
  output logic [7:0]      rx_byte_o,    // demod byte
  output logic            rx_end_o,     // end of reply
  output logic            ext_field_o   // target field seen by detector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];  // bytes sent over the air
  logic       ph;      // stall phase
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_end_o = 1'b0;
    ext_field_o = 1'b0;
    ph = 1'b0;
  end
  // record each taken byte; a slow target halves the byte rate
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_byte_i);
    end
    ph <= ~ph;
    tx_ready_o <= !stall_i || ph;
  end
  // target switches its field; a field at init time is a collision
  task automatic field(input logic on);
    ext_field_o <= on;
  endtask
  // reply bytes with gaps; the bus never shows a stale byte between strobes
  task automatic reply(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rx_byte_o <= b[i];
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~b[i];
      @(posedge clk_i);
    end
    rx_end_o <= 1'b1;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the peer framing sequencer
`default_nettype none
`include "nfcps_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IRFG = 50;  // short initial guard for sim
  localparam int GP = 40;    // field hold after a message
  localparam int NRT = 300;  // no-response wait
  localparam int MRT = 10;   // receive mask
  logic        clk_i, reset_i, wr_i, rd_i, stall;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic        tx_valid_o, tx_last_o, field_on_o, thresh_ca_o, rx_window_o;
  logic [7:0]  tx_byte_o, rx_byte;
  logic        tx_ready, rx_valid, rx_end, ext_field;
  logic [7:0]  q[$];  // reply under construction
  int          errors, samples_checked, k, n, want;
  nfcps_sequencer #(.IRFG_CYC(IRFG)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_field_i(ext_field),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_end_i(rx_end),
    .tx_ready_i(tx_ready), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
    .tx_last_o(tx_last_o), .field_on_o(field_on_o), .thresh_ca_o(thresh_ca_o),
    .rx_window_o(rx_window_o));
  nfcps_rf_peer peer (
    .clk_i(clk_i), .stall_i(stall), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
    .rx_end_o(rx_end), .ext_field_o(ext_field));
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write, then an idle edge so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one-cycle read; data stand only in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    @(posedge clk_i);
  endtask
  // read and compare the masked bits
  task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask
  // bounded wait on a settled output; cycles waited in k
  task automatic wait_for(input int sel, input int lim);
    for (k = 0; k < lim; k++) begin
      @(negedge clk_i);
      if ((sel == 0 && field_on_o === 1'b1) || (sel == 1 && field_on_o === 1'b0) ||
          (sel == 2 && rx_window_o === 1'b1) || (sel == 3 && peer.got.size() >= want)) break;
    end
    if (k >= lim) begin
      errors++;
      end_sim;
    end
    @(posedge clk_i);
  endtask
  // crc over bytes, lsb first, reflected polynomial
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `NFCPS_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction
  // send n data bytes as a transport frame and check the air bytes
  task automatic send_frame;
    logic [7:0]  e[$];
    logic [15:0] c;
    e = {`NFCPS_START_BYTE, 8'(n + 1)};
    wr(`NFCPS_REG_TXCNT, 16'(n));
    for (int i = 0; i < n; i++) begin
      wr(`NFCPS_REG_TXDATA, {4'h0, 4'(i), 8'ha0 + 8'(i)});
      e.push_back(8'ha0 + 8'(i));
    end
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    want = e.size();
    wr(`NFCPS_REG_CMD, {8'h00, `NFCPS_CMD_TX_CRC});
    wait_for(3, 2000);
    foreach (e[i]) chk(16'(peer.got[i]), 16'(e[i]));
    peer.got.delete();
    wait_for(1, GP + 50);
    chk(16'(k >= GP - 4 && k <= GP + 8), 16'h0001);
  endtask
  // free-running clock, 10 ns
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // main sequence
  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    stall = 1'b1;
    errors = 0;
    samples_checked = 0;
    n = 0;
    want = 0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rc(`NFCPS_REG_MODE, 16'hffff, `NFCPS_MODE_RESET);
    rc(4'hf, 16'hffff, 16'h0000);
    // active initiator at 106, target role clear, then preset
    wr(`NFCPS_REG_MODE, 16'h0005);
    wr(`NFCPS_REG_CMD, {8'h00, `NFCPS_CMD_PRESET});
    rc(`NFCPS_REG_MODE, 16'h01c8, 16'h00c8);
    wr(`NFCPS_REG_GPTIME, 16'(GP));
    wr(`NFCPS_REG_NRTIME, 16'(NRT));
    wr(`NFCPS_REG_MRTIME, 16'(MRT));
    // a foreign field is present: field must stay off
    peer.field(1'b1);
    repeat (20) @(posedge clk_i);
    wr(`NFCPS_REG_CMD, {8'h00, `NFCPS_CMD_INIT_ON});
    repeat (9000) @(posedge clk_i);
    rc(`NFCPS_REG_MODE, 16'h0020, 16'h0000);
    rc(`NFCPS_REG_EVENTS, 16'h0003, 16'h0002);
    // retry once the air is quiet
    peer.field(1'b0);
    repeat (20) @(posedge clk_i);
    wr(`NFCPS_REG_CMD, {8'h00, `NFCPS_CMD_INIT_ON});
    wait_for(0, 20000);
    rc(`NFCPS_REG_MODE, 16'h0020, 16'h0020);
    repeat (IRFG + 20) @(posedge clk_i);
    rc(`NFCPS_REG_EVENTS, 16'h0003, 16'h0001);
    // auto response on, then a frame of n = 3 data bytes
    rd(`NFCPS_REG_MODE, v);
    wr(`NFCPS_REG_MODE, v | 16'h0010);
    n = 3;
    send_frame;
    // target answers: window opens only after the mask
    peer.field(1'b1);
    wait_for(2, MRT + 40);
    chk(16'(k >= MRT - 2), 16'h0001);
    rc(`NFCPS_REG_EVENTS, 16'h000c, 16'h0008);
    // reply with a wrong start byte: data kept, soft framing error
    q = {8'h0f, 8'h03, 8'h5a, 8'ha5};
    v = crc(q);
    q.push_back(v[7:0]);
    q.push_back(v[15:8]);
    peer.reply(q);
    repeat (5) @(posedge clk_i);
    rc(`NFCPS_REG_EVENTS, 16'h0020, 16'h0020);
    rc(`NFCPS_REG_RXDATA, 16'h00ff, 16'h0003);
    // target drops its field: automatic response field-on
    peer.field(1'b0);
    wait_for(0, 20000);
    repeat (7600) @(posedge clk_i);
    rc(`NFCPS_REG_EVENTS, 16'h0013, 16'h0011);
    // last exchange: stop auto response, send an empty frame
    rd(`NFCPS_REG_MODE, v);
    wr(`NFCPS_REG_MODE, v & ~16'h0010);
    stall <= 1'b0;
    n = 0;
    send_frame;
    repeat (NRT + 100) @(posedge clk_i);
    rc(`NFCPS_REG_EVENTS, 16'h0004, 16'h0004);
    end_sim;
  end
endmodule
`default_nettype wire
